// file: design/irq_pkg.sv
// Functional notes
// RULE1 - many sources gathered onto ten vectors
// RULE2 - three levels: highest, high, low
// RULE3 - nest only strictly higher level requests
// RULE4 - simultaneous vectors: highest level wins
// RULE5 - equal level: smallest vector address wins
// RULE6 - first two vectors: highest or low
// RULE7 - other eight vectors: high or low
// RULE8 - vectors 13h,1bh source groups
// RULE9 - vectors 23h,2bh source groups
// RULE10 - vectors 33h,3bh source groups
// RULE11 - vectors 43h,4bh source groups
// RULE12 - source flag list names branch causes
// RULE13 - branch request, raise level, restore on return
`default_nettype none
package irq_pkg;
  localparam int SRC_COUNT = 32;            // source flag inputs
  localparam int VEC_COUNT = 10;            // vector addresses
  localparam int ADDR_W    = 17;            // program address width
  // level codes, ordered so a larger code is a higher level
  localparam logic [1:0] LVL_NONE = 2'h0;   // no request / idle
  localparam logic [1:0] LVL_LOW  = 2'h1;   // low
  localparam logic [1:0] LVL_HIGH = 2'h2;   // high
  localparam logic [1:0] LVL_TOP  = 2'h3;   // highest
  // vector address = base + step * vector index
  localparam logic [16:0] VEC_BASE = 17'h00003;
  localparam logic [16:0] VEC_STEP = 17'h00008;
  // vectors below this index are the external line zero/one vectors
  localparam int EXT_VEC_COUNT = 2;
  // source bit positions
  localparam int SRC_EXT0 = 0, SRC_EXT1 = 1;
  localparam int SRC_EXT2 = 2, SRC_T0L = 3, SRC_EXT4 = 4, SRC_RRX1 = 5;
  localparam int SRC_EXT3 = 6, SRC_BASE = 7, SRC_EXT5 = 8, SRC_RRX2 = 9;
  localparam int SRC_T0H = 10, SRC_EXT6 = 11;
  localparam int SRC_T1L = 12, SRC_T1H = 13, SRC_EXT7 = 14;
  localparam int SRC_SYNC_SERIAL_PORT_ZERO = 15, SRC_U1RX = 16, SRC_U2RX = 17;
  localparam int SRC_T8L = 18, SRC_T8H = 19;
  localparam int SRC_SYNC_SERIAL_PORT_ONE = 20, SRC_U1TX = 21, SRC_U2TX = 22;
  localparam int SRC_ADC = 23, SRC_SSD = 24, SRC_T6 = 25, SRC_T7 = 26;
  localparam int SRC_PWA = 27, SRC_PWB = 28;
  localparam int SRC_P0 = 29, SRC_T4 = 30, SRC_T5 = 31;
  // which source flags share each vector
  localparam logic [31:0] VEC_MASK [VEC_COUNT] = '{
    32'h0000_0001,  // 00003h: ext line zero
    32'h0000_0002,  // 0000bh: ext line one
    32'h0000_003c,  // 00013h: ext2, timer0 low, ext4, remote rx1
    32'h0000_03c0,  // 0001bh: ext3, base timer, ext5, remote rx2
    32'h0000_0c00,  // 00023h: timer0 high, ext6
    32'h0000_7000,  // 0002bh: timer1 low/high, ext7
    32'h000f_8000,  // 00033h: sync_serial_port_zero, both async rx, timer8 low/high
    32'h0070_0000,  // 0003bh: sync_serial_port_one, both async tx
    32'h1f80_0000,  // 00043h: adc, detector, t6, t7, both pulse outs
    32'he000_0000   // 0004bh: port0, t4, t5
  };
  // per-vector configuration from the core's control logic
  typedef struct packed {
    logic [VEC_COUNT-1:0] enable;   // vector enable
    logic [VEC_COUNT-1:0] lvl_up;   // 1: upper level of the pair
  } irq_cfg_t;
  // branch request towards the core
  typedef struct packed {
    logic              req;         // branch pending
    logic [16:0]       addr;        // vector address
    logic [1:0]        level;       // level of the request
  } irq_branch_t;
endpackage
`default_nettype wire

// file: design/irq_vec_slot.sv
`default_nettype none
// one vector: merges its source flags and maps its level choice
module irq_vec_slot #(
  parameter bit EXT_PAIR = 1'b0               // 1: highest/low pair
) (
  input  wire logic [31:0] flags,             // all source flags
  input  wire logic [31:0] mask,              // this vector's sources
  input  wire logic        enable,            // vector enabled
  input  wire logic        lvl_up,            // upper level chosen
  output logic      [1:0]  req_lvl            // requested level or none
);
  logic hit;                                  // any own source raised
  assign hit = |(flags & mask);
  // level mapping per vector kind
  always_comb begin
    if (!(hit && enable)) begin
      req_lvl = irq_pkg::LVL_NONE;
    end else if (!lvl_up) begin
      req_lvl = irq_pkg::LVL_LOW;
    end else if (EXT_PAIR) begin
      req_lvl = irq_pkg::LVL_TOP;             // RULE6
    end else begin
      req_lvl = irq_pkg::LVL_HIGH;            // RULE7
    end
  end
endmodule // irq_vec_slot
`default_nettype wire

// file: design/irq_ctrl.sv
`default_nettype none
// vectored three-level interrupt controller facing the core
module irq_ctrl (
  input  wire logic                sys_clk,   // system clock
  input  wire logic                nrst,      // sync reset, active low
  input  wire logic [31:0]         src_flag,  // peripheral source flags
  input  wire irq_pkg::irq_cfg_t   cfg,       // enables and level choice
  input  wire logic                core_ack,  // core takes the branch
  input  wire logic                core_ret,  // handler return pulse
  output irq_pkg::irq_branch_t     branch_r,  // branch request to core
  output logic [31:0]              source_flag_list_r, // causing flags
  output logic [1:0]               serv_level_r // level in service
);
  typedef enum logic {ST_IDLE, ST_BRANCH} state_t;

  state_t            state_r;                 // handshake state
  logic [3:1]        insvc_r;                 // in-service per level
  logic [1:0]        slot_lvl [10];           // request level per vector
  logic [1:0]        cur_lvl;                 // highest level in service
  logic [1:0]        best_lvl;                // winning request level
  logic [3:0]        best_vec;                // winning vector index
  logic              accept;                  // grant this cycle

  // one slot per vector gathers its shared sources
  for (genvar v = 0; v < irq_pkg::VEC_COUNT; v++) begin : g_slot
    irq_vec_slot #(
      .EXT_PAIR (v < irq_pkg::EXT_VEC_COUNT)
    ) u_slot (
      .flags   (src_flag),
      .mask    (irq_pkg::VEC_MASK[v]),        // RULE1 RULE8 RULE9
      .enable  (cfg.enable[v]),               // RULE10 RULE11
      .lvl_up  (cfg.lvl_up[v]),
      .req_lvl (slot_lvl[v])
    );
  end

  // current service level is the highest in-service bit
  always_comb begin
    if (insvc_r[3]) begin
      cur_lvl = irq_pkg::LVL_TOP;             // RULE2
    end else if (insvc_r[2]) begin
      cur_lvl = irq_pkg::LVL_HIGH;
    end else if (insvc_r[1]) begin
      cur_lvl = irq_pkg::LVL_LOW;
    end else begin
      cur_lvl = irq_pkg::LVL_NONE;
    end
  end

  // arbitration: strict compare keeps the lowest vector on a tie
  always_comb begin
    best_lvl = irq_pkg::LVL_NONE;
    best_vec = 4'h0;
    for (int v = 0; v < irq_pkg::VEC_COUNT; v++) begin
      if (slot_lvl[v] > best_lvl) begin       // RULE4 RULE5
        best_lvl = slot_lvl[v];
        best_vec = 4'(v);
      end
    end
  end

  // only strictly higher requests are accepted while idle
  assign accept = (state_r == ST_IDLE) && (best_lvl > cur_lvl) // RULE3
                  && !core_ret;

  // handshake with the core
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (accept) begin
            state_r <= ST_BRANCH;             // RULE13
          end
        end
        ST_BRANCH: begin
          if (core_ack) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // branch request: address and level latched at grant
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      branch_r <= '0;
    end else if (accept) begin
      branch_r.req   <= 1'b1;                 // RULE13
      branch_r.addr  <= irq_pkg::VEC_BASE
                        + 17'(irq_pkg::VEC_STEP * best_vec);
      branch_r.level <= best_lvl;
    end else if (state_r == ST_BRANCH && core_ack) begin
      branch_r.req   <= 1'b0;
    end
  end

  // snapshot of the granted vector's own raised flags
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      source_flag_list_r <= '0;
    end else if (accept) begin
      source_flag_list_r <= src_flag & irq_pkg::VEC_MASK[best_vec]; // RULE12
    end
  end

  // in-service bits: set on ack, highest cleared on return
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      insvc_r <= '0;
    end else if (state_r == ST_BRANCH && core_ack) begin
      insvc_r[branch_r.level] <= 1'b1;        // RULE13
    end else if (core_ret) begin
      if (insvc_r[3]) begin
        insvc_r[3] <= 1'b0;                   // RULE13
      end else if (insvc_r[2]) begin
        insvc_r[2] <= 1'b0;
      end else begin
        insvc_r[1] <= 1'b0;
      end
    end
  end

  // service level shown to the core
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      serv_level_r <= irq_pkg::LVL_NONE;
    end else begin
      serv_level_r <= cur_lvl;
    end
  end
endmodule // irq_ctrl
`default_nettype wire

// file: tb/core_model.sv
`default_nettype none
// core side: acks a pending branch after ack_dly cycles
module core_model (
  input  wire logic                 sys_clk,  // clock
  input  wire logic                 nrst,     // sync reset
  input  wire irq_pkg::irq_branch_t branch_r, // branch request
  input  wire logic [3:0]           ack_dly,  // cycles before ack
  input  wire logic                 ret_cmd,  // bench asks a return
  output logic                      core_ack, // branch taken
  output logic                      core_ret  // handler return
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r; // cycles waited so far
  // the return pulse passes straight through from the bench
  assign core_ret = ret_cmd;
  // one-cycle ack off the falling edge, never twice per branch
  always @(negedge sys_clk) begin
    core_ack <= 1'b0;
    if (!nrst || !branch_r.req || core_ack) begin
      wait_r <= 4'h0;
    end else if (wait_r >= ack_dly) begin
      core_ack <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule // core_model
`default_nettype wire

// file: tb/irq_ctrl_properties.sv
`default_nettype none
// handshake, nesting and flag-list checks at the ports
module irq_ctrl_checker (
  input wire logic                 sys_clk,            // clock
  input wire logic                 nrst,               // sync reset
  input wire logic [31:0]          src_flag,           // source flags
  input wire irq_pkg::irq_cfg_t    cfg,                // vector config
  input wire logic                 core_ack,           // branch taken
  input wire logic                 core_ret,           // return
  input wire irq_pkg::irq_branch_t branch_r,           // branch request
  input wire logic [31:0]          source_flag_list_r, // causes
  input wire logic [1:0]           serv_level_r        // in service
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] idx; // vector index of the request
  logic [1:0] up;  // upper level of that vector
  assign idx = 4'((branch_r.addr - irq_pkg::VEC_BASE) >> 3);
  assign up = (idx < 4'h2) ? irq_pkg::LVL_TOP : irq_pkg::LVL_HIGH;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  sequence s_grant;
    $rose(branch_r.req);
  endsequence
  a_req_holds: assert property (
    branch_r.req && !core_ack |=> branch_r.req && $stable(branch_r))
    else $error("branch changed before ack");
  a_ack_drops: assert property (
    branch_r.req && core_ack |=> !branch_r.req)
    else $error("branch stayed after ack");
  a_nest_above: assert property (
    s_grant |-> branch_r.level > serv_level_r)
    else $error("grant not above service level");
  a_list_cause: assert property (
    s_grant |-> source_flag_list_r != 32'h0
      && (source_flag_list_r & ~$past(src_flag)) == 32'h0)
    else $error("flag list not from raised flags");
  a_list_vector: assert property (
    s_grant |-> (source_flag_list_r & ~irq_pkg::VEC_MASK[idx]) == 32'h0)
    else $error("flag list outside vector");
  a_level_pair: assert property (
    s_grant |-> cfg.enable[idx]
      && branch_r.level == (cfg.lvl_up[idx] ? up : irq_pkg::LVL_LOW))
    else $error("wrong level for vector");
  a_ret_blocks: assert property (
    core_ret |=> !$rose(branch_r.req))
    else $error("grant on return cycle");
  a_serv_lag: assert property (
    branch_r.req && core_ack |-> ##2 serv_level_r == $past(branch_r.level, 2))
    else $error("service level not raised");
endmodule // irq_ctrl_checker
bind irq_ctrl irq_ctrl_checker u_irq_ctrl_checker (.sys_clk(sys_clk),
  .nrst(nrst), .src_flag(src_flag), .cfg(cfg), .core_ack(core_ack),
  .core_ret(core_ret), .branch_r(branch_r),
  .source_flag_list_r(source_flag_list_r), .serv_level_r(serv_level_r));
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 sys_clk, nrst, core_ack, core_ret, ret_cmd;
  logic [31:0]          src_flag, source_flag_list_r; // flags, causes
  logic [3:0]           ack_dly;       // core ack delay
  logic [1:0]           serv_level_r;  // level in service
  irq_pkg::irq_cfg_t    cfg;           // enables and levels
  irq_pkg::irq_branch_t branch_r;      // branch request
  int                   fails, checks_done;
  irq_ctrl u_irq_ctrl (.sys_clk(sys_clk), .nrst(nrst), .src_flag(src_flag),
    .cfg(cfg), .core_ack(core_ack), .core_ret(core_ret), .branch_r(branch_r),
    .source_flag_list_r(source_flag_list_r), .serv_level_r(serv_level_r));
  core_model u_core_model (.sys_clk(sys_clk), .nrst(nrst),
    .branch_r(branch_r), .ack_dly(ack_dly), .ret_cmd(ret_cmd),
    .core_ack(core_ack), .core_ret(core_ret));
  // 25 mhz system clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // single closing point: verdict, then end of run
  task automatic stop_test();
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // compare seen against expected, count mismatches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // wait for a branch, judge it, let the core take it
  task automatic grant(input int v, input int lv, input logic [31:0] ls);
    for (int n = 0; n < 20 && branch_r.req !== 1'b1; n++) begin
      @(negedge sys_clk);
    end
    chk(32'(branch_r.req), 32'h1);
    chk(32'(branch_r.addr), 32'(3 + 8 * v));
    chk(32'(branch_r.level), 32'(lv));
    chk(source_flag_list_r, ls);
    repeat (6) @(negedge sys_clk);
  endtask
  // no branch may appear for six cycles
  task automatic quiet();
    repeat (6) begin
      @(negedge sys_clk);
      chk(32'(branch_r.req), 32'h0);
    end
  endtask
  // one-cycle handler return pulse, then one idle cycle
  task automatic ret();
    ret_cmd = 1'b1;
    @(negedge sys_clk);
    ret_cmd = 1'b0;
    @(negedge sys_clk);
  endtask
  // each source alone reaches its own vector
  task automatic t_map();
    int first[10] = '{0, 1, 2, 6, 10, 12, 15, 20, 23, 29};
    int v;
    for (int s = 0; s < 32; s++) begin
      v = 0;
      for (int k = 0; k < 10; k++) v = (s >= first[k]) ? k : v;
      src_flag = 32'h1 << s;
      grant(v, 1, 32'h1 << s);
      src_flag = 32'h0;
      ret();
    end
  endtask
  // simultaneous vectors: level first, then lowest address
  task automatic t_prio();
    cfg.enable = 10'h3fe;
    src_flag = 32'h1;
    quiet();
    cfg.enable = 10'h3ff;
    ack_dly = 4'h3;
    src_flag = 32'h8080_0040;
    grant(3, 1, 32'h40);
    cfg.lvl_up = 10'h200;
    src_flag = 32'h8000_0005;
    ret();
    grant(9, 2, 32'h8000_0000);
    cfg.lvl_up = 10'h201;
    ret();
    grant(0, 3, 32'h1);
    src_flag = 32'h0;
    ret();
  endtask
  // nesting refuses equal and lower levels
  task automatic t_nest();
    ack_dly = 4'h1;
    cfg.lvl_up = 10'h281;
    src_flag = 32'h2000_0000;
    grant(9, 2, 32'h2000_0000);
    src_flag = 32'h2010_8000;
    quiet();
    src_flag = 32'h2010_8001;
    grant(0, 3, 32'h1);
    chk(32'(serv_level_r), 32'h3);
    src_flag = 32'h0010_8000;
    ret();
    quiet();
    chk(32'(serv_level_r), 32'h2);
    ret();
    grant(7, 2, 32'h0010_0000);
    src_flag = 32'h0000_8000;
    ret();
    grant(6, 1, 32'h8000);
    src_flag = 32'h0;
    ret();
  endtask
  // reset for 20 cycles, then the scenarios in turn
  initial begin
    {nrst, ret_cmd, src_flag, ack_dly} = '0;
    cfg = '{enable: 10'h3ff, lvl_up: 10'h0};
    fails = 0;
    checks_done = 0;
    repeat (20) @(negedge sys_clk);
    nrst = 1'b1;
    t_map();
    t_prio();
    t_nest();
    stop_test();
  end
  // watchdog: the scenarios need well under 1000 cycles
  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
